// ---- hdl/lpwsc_pkg.sv ----
// constants for the low-power wait and stop controller
package lpwsc_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] LPWSC_CTRL_ADDR = 4'h0;
	localparam logic [3:0] LPWSC_STAT_ADDR = 4'h4;
	localparam logic [3:0] LPWSC_DLYC_ADDR = 4'h8;
	localparam int LPWSC_ADDR_W = 4;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTL_DELAY_SEL = 0;
	localparam int CTL_WDOG_DIS = 1;
	localparam int CTL_T2_STOP = 2;
	localparam int CTL_T3_STOP = 3;
	localparam int CTL_ADC_PU = 4;
	localparam int CTL_ADC_RC = 5;
	localparam int CTL_SPI_EN = 6;
	localparam int CTL_TX_EN = 7;
	localparam int CTL_RX_EN = 8;
	localparam int CTL_PWM_LO = 9;
	localparam int CTL_IRQ_EDGE = 13;
	localparam int CTL_W = 14;
	localparam logic [CTL_W-1:0] CTL_RESET = 14'h0001;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int ST_FLAG = 0;
	localparam int ST_WAIT = 1;
	localparam int ST_STOP = 2;
	localparam int ST_DELAY = 3;
	localparam int ST_I = 4;
	localparam int ST_X = 5;
	localparam int ST_S = 6;

	// ----------------------------------------------------------------
	// condition code bit positions in the 3-bit view {s,x,i}
	// ----------------------------------------------------------------
	localparam int CC_I = 0;
	localparam int CC_X = 1;
	localparam int CC_S = 2;
	localparam logic [2:0] CC_RESET = 3'h7;

	// ----------------------------------------------------------------
	// timing and bus answers
	// ----------------------------------------------------------------
	localparam int DLY_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int PWM_CH = 4;

	typedef enum logic [2:0] {
		LP_BOOT, LP_RUN, LP_STACK, LP_WAIT, LP_STOP, LP_DELAY
	} lpwsc_state_type;
endpackage : lpwsc_pkg

// ---- hdl/lpwsc_top.sv ----
// low-power wait/stop control with wake-up paths and axi4-lite registers
`timescale 1ns/100ps
module lpwsc_top import lpwsc_pkg::*; #(
	parameter int PERIPH_N = 8, // internal interrupt sources
	parameter int RESTART_DELAY_CYCLES = 4064 // default stabilisation cycles
) (
	input wire logic aclk, // system clock, 20 MHz
	input wire logic aresetn, // chip reset, sync, active low
	input wire logic [LPWSC_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [LPWSC_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic irq_n_pin, // wired-or maskable request pin
	input wire logic nonmaskable_request_n, // nonmaskable request pin
	input wire logic power_on_pin, // high when reset came from power-on
	input wire logic [PERIPH_N-1:0] periph_irq, // internal interrupt requests
	input wire logic wait_opcode, // core decoded wait, pulse
	input wire logic stop_opcode, // core decoded stop, pulse
	input wire logic stack_done, // core finished stacking, pulse
	input wire logic [15:0] ccr_stack_addr, // where the ccr byte was stacked
	input wire logic int_taken, // core stacked ccr for an interrupt, pulse
	input wire logic int_taken_nmi, // with int_taken: nonmaskable source
	input wire logic ccr_load, // core writes s/x/i, pulse
	input wire logic [2:0] ccr_load_value, // {s,x,i} from transfer instruction
	input wire logic rti_restore, // return from interrupt, pulse
	input wire logic [2:0] rti_value, // {s,x,i} pulled from stack
	output logic [2:0] condition_code_reg, // {s,x,i} mask bits
	output logic stack_request, // ask core to stack registers
	output logic cpu_halt, // core suspended
	output logic osc_enable, // crystal oscillator runs
	output logic wake_resume, // resume in place, pulse
	output logic nmi_continue_next, // stop left with nmi masked, pulse
	output logic irq_service_request, // maskable pin service request
	output logic nmi_service_request, // nonmaskable service request
	output logic wait_bus_read, // idle read strobe during wait
	output logic [15:0] wait_bus_addr, // idle read address during wait
	output logic timer1_clk_en, // timer 1 clock enable
	output logic timer2_clk_en, // timer 2 clock enable
	output logic timer3_clk_en, // timer 3 clock enable
	output logic converter_power, // converter analog power
	output logic converter_clk_en, // converter rc clock enable
	output logic sync_serial_clk_en, // synchronous serial clock enable
	output logic async_tx_clk_en, // asynchronous transmitter enable
	output logic async_rx_clk_en, // asynchronous receiver enable
	output logic [PWM_CH-1:0] pwm_clk_en // per pulse channel enable
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic irq_s1_reg, irq_s2_reg, irq_s3_reg;
	logic nmi_s1_reg, nmi_s2_reg;
	logic por_s1_reg, por_s2_reg;

	// two flops per pin; irq gets a third for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_s1_reg <= 1'b1;
			irq_s2_reg <= 1'b1;
			irq_s3_reg <= 1'b1;
			nmi_s1_reg <= 1'b1;
			nmi_s2_reg <= 1'b1;
		end else begin
			irq_s1_reg <= irq_n_pin;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
			nmi_s1_reg <= nonmaskable_request_n;
			nmi_s2_reg <= nmi_s1_reg;
		end
	end

	// the power-on strap must still be sampled while reset is held
	always_ff @(posedge aclk) begin
		por_s1_reg <= power_on_pin;
		por_s2_reg <= por_s1_reg;
	end

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [CTL_W-1:0] ctrl_reg;
	logic [DLY_W-1:0] dly_cycles_reg;
	logic [DLY_W-1:0] dly_cnt_reg;
	logic irq_flag_reg;
	logic [2:0] ccr_reg;
	lpwsc_state_type state_reg, state_next;
	logic nmi_masked_wake_reg;
	logic [15:0] stack_addr_reg;

	logic wr_fire, rd_fire, flag_clr, flag_set;
	logic irq_low, irq_fall, nmi_low;
	logic irq_req, nmi_req, periph_req, any_unmasked;
	logic stop_wake, stopped, in_wait;

	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
	assign irq_low = !irq_s2_reg;
	assign irq_fall = irq_s3_reg && !irq_s2_reg;
	assign nmi_low = !nmi_s2_reg;

	// ----------------------------------------------------------------
	// external request flag
	// ----------------------------------------------------------------
	// level mode re-sets while any source still pulls low; set beats clear
	assign flag_set = ctrl_reg[CTL_IRQ_EDGE] ? irq_fall : irq_low;
	assign flag_clr = wr_fire && s_axi_awaddr == LPWSC_STAT_ADDR && s_axi_wstrb[0] && s_axi_wdata[ST_FLAG];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag_reg <= 1'b0;
		end else if (flag_set) begin
			irq_flag_reg <= 1'b1;
		end else if (flag_clr) begin
			irq_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt qualification
	// ----------------------------------------------------------------
	assign irq_req = irq_flag_reg && !ccr_reg[CC_I];
	assign nmi_req = nmi_low && !ccr_reg[CC_X];
	assign periph_req = (|periph_irq) && !ccr_reg[CC_I];
	assign any_unmasked = irq_req || nmi_req || periph_req;
	// maskable pin and pending edge only with i clear; nmi pin always
	assign stop_wake = nmi_low || irq_req;
	assign irq_service_request = irq_req;
	assign nmi_service_request = nmi_req && !cpu_halt;

	// ----------------------------------------------------------------
	// condition code mask bits
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ccr_reg <= CC_RESET;
		end else if (rti_restore) begin
			ccr_reg <= rti_value;
		end else if (int_taken) begin
			ccr_reg[CC_I] <= 1'b1;
			if (int_taken_nmi) begin
				ccr_reg[CC_X] <= 1'b1;
			end
		end else if (ccr_load) begin
			// once cleared, x cannot be set again by software
			ccr_reg <= {ccr_load_value[CC_S], ccr_load_value[CC_X] & ccr_reg[CC_X], ccr_load_value[CC_I]};
		end
	end
	assign condition_code_reg = ccr_reg;

	// ----------------------------------------------------------------
	// low-power state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LP_BOOT: begin
				// a running-clock reset skips the delay
				state_next = por_s2_reg ? LP_DELAY : LP_RUN;
			end
			LP_RUN: begin
				if (wait_opcode) begin
					state_next = LP_STACK;
				end else if (stop_opcode && !ccr_reg[CC_S]) begin
					state_next = LP_STOP;
				end
			end
			LP_STACK: begin
				if (stack_done) begin
					state_next = LP_WAIT;
				end
			end
			LP_WAIT: begin
				if (any_unmasked) begin
					state_next = LP_RUN;
				end
			end
			LP_STOP: begin
				if (stop_wake) begin
					state_next = ctrl_reg[CTL_DELAY_SEL] ? LP_DELAY : LP_RUN;
				end
			end
			LP_DELAY: begin
				if (dly_cnt_reg == '0) begin
					state_next = LP_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= LP_BOOT;
		end else begin
			state_reg <= state_next;
		end
	end

	// stabilisation counter, loaded on entry to the delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_cnt_reg <= '0;
		end else if (state_next == LP_DELAY && state_reg != LP_DELAY) begin
			dly_cnt_reg <= dly_cycles_reg - 1'b1;
		end else if (state_reg == LP_DELAY && dly_cnt_reg != '0) begin
			dly_cnt_reg <= dly_cnt_reg - 1'b1;
		end
	end

	// remember whether nmi woke us while masked, to report after the delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_masked_wake_reg <= 1'b0;
		end else if (state_reg == LP_STOP && stop_wake) begin
			nmi_masked_wake_reg <= nmi_low && ccr_reg[CC_X];
		end else if (state_reg == LP_RUN) begin
			nmi_masked_wake_reg <= 1'b0;
		end
	end

	// wake strobes to the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_resume <= 1'b0;
			nmi_continue_next <= 1'b0;
		end else begin
			wake_resume <= state_next == LP_RUN && (state_reg == LP_WAIT || state_reg == LP_STOP
				|| state_reg == LP_DELAY);
			nmi_continue_next <= state_next == LP_RUN && state_reg != LP_RUN
				&& (state_reg == LP_DELAY ? nmi_masked_wake_reg : state_reg == LP_STOP && nmi_low
				&& ccr_reg[CC_X]);
		end
	end

	// ----------------------------------------------------------------
	// wait-state idle bus reads
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_addr_reg <= 16'h0000;
		end else if (state_reg == LP_STACK && stack_done) begin
			stack_addr_reg <= ccr_stack_addr;
		end
	end
	assign wait_bus_read = state_reg == LP_WAIT;
	assign wait_bus_addr = stack_addr_reg;

	// ----------------------------------------------------------------
	// clock gating
	// ----------------------------------------------------------------
	assign stopped = state_reg == LP_STOP || state_reg == LP_DELAY || state_reg == LP_BOOT;
	assign in_wait = state_reg == LP_WAIT || state_reg == LP_STACK;
	assign stack_request = state_reg == LP_STACK;
	assign cpu_halt = state_reg != LP_RUN;
	// only stop idles the oscillator; delay already lets it settle
	assign osc_enable = state_reg != LP_STOP;
	assign timer1_clk_en = !stopped && !(in_wait && ccr_reg[CC_I] && ctrl_reg[CTL_WDOG_DIS]);
	assign timer2_clk_en = !stopped && !(in_wait && ctrl_reg[CTL_T2_STOP]);
	assign timer3_clk_en = !stopped && !(in_wait && ctrl_reg[CTL_T3_STOP]);
	assign converter_power = ctrl_reg[CTL_ADC_PU];
	assign converter_clk_en = !stopped && ctrl_reg[CTL_ADC_RC];
	assign sync_serial_clk_en = !stopped && ctrl_reg[CTL_SPI_EN];
	assign async_tx_clk_en = !stopped && ctrl_reg[CTL_TX_EN];
	assign async_rx_clk_en = !stopped && ctrl_reg[CTL_RX_EN];

	// one enable per pulse channel
	genvar ch;
	generate
		for (ch = 0; ch < PWM_CH; ch++) begin : g_pwm
			assign pwm_clk_en[ch] = !stopped && ctrl_reg[CTL_PWM_LO + ch];
		end
	endgenerate

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = rd_fire;

	// control register, byte lanes honoured; reset sets delay-select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTL_RESET;
		end else if (wr_fire && s_axi_awaddr == LPWSC_CTRL_ADDR) begin
			if (s_axi_wstrb[0]) begin
				ctrl_reg[7:0] <= s_axi_wdata[7:0];
			end
			if (s_axi_wstrb[1]) begin
				ctrl_reg[CTL_W-1:8] <= s_axi_wdata[CTL_W-1:8];
			end
		end
	end

	// stabilisation length register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_cycles_reg <= DLY_W'(RESTART_DELAY_CYCLES);
		end else if (wr_fire && s_axi_awaddr == LPWSC_DLYC_ADDR) begin
			if (s_axi_wstrb[0]) begin
				dly_cycles_reg[7:0] <= s_axi_wdata[7:0];
			end
			if (s_axi_wstrb[1]) begin
				dly_cycles_reg[15:8] <= s_axi_wdata[15:8];
			end
		end
	end

	// write response one cycle after both channels are taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (s_axi_awaddr == LPWSC_CTRL_ADDR || s_axi_awaddr == LPWSC_STAT_ADDR
				|| s_axi_awaddr == LPWSC_DLYC_ADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read data; unmapped addresses answer slverr with zero data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			unique case (s_axi_araddr)
				LPWSC_CTRL_ADDR: s_axi_rdata[CTL_W-1:0] <= ctrl_reg;
				LPWSC_STAT_ADDR: begin
					s_axi_rdata[ST_FLAG] <= irq_flag_reg;
					s_axi_rdata[ST_WAIT] <= state_reg == LP_WAIT;
					s_axi_rdata[ST_STOP] <= state_reg == LP_STOP;
					s_axi_rdata[ST_DELAY] <= state_reg == LP_DELAY;
					s_axi_rdata[ST_I] <= ccr_reg[CC_I];
					s_axi_rdata[ST_X] <= ccr_reg[CC_X];
					s_axi_rdata[ST_S] <= ccr_reg[CC_S];
				end
				LPWSC_DLYC_ADDR: s_axi_rdata[DLY_W-1:0] <= dly_cycles_reg;
				default: s_axi_rresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : lpwsc_top

// ---- verification/lpwsc_props.sv ----
// concurrent checks on the ports of the wait/stop controller
`timescale 1ns/100ps
module lpwsc_props import lpwsc_pkg::*; (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic wait_opcode, // wait decoded
	input wire logic stop_opcode, // stop decoded
	input wire logic stack_done, // stacking finished
	input wire logic [15:0] ccr_stack_addr, // stacked ccr address
	input wire logic int_taken, // interrupt stacked
	input wire logic int_taken_nmi, // source was nonmaskable
	input wire logic rti_restore, // return from interrupt
	input wire logic [2:0] rti_value, // pulled {s,x,i}
	input wire logic nonmaskable_request_n, // nonmaskable pin
	input wire logic [2:0] condition_code_reg, // {s,x,i}
	input wire logic stack_request, // stacking asked
	input wire logic cpu_halt, // core suspended
	input wire logic osc_enable, // oscillator runs
	input wire logic wake_resume, // resume pulse
	input wire logic nmi_continue_next, // continue pulse
	input wire logic irq_service_request, // maskable request
	input wire logic wait_bus_read, // idle read strobe
	input wire logic [15:0] wait_bus_addr, // idle read address
	input wire logic timer1_clk_en, // timer 1 enable
	input wire logic timer2_clk_en, // timer 2 enable
	input wire logic timer3_clk_en, // timer 3 enable
	input wire logic [PWM_CH-1:0] pwm_clk_en // pulse channel enables
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	sequence s_run_stop;
		stop_opcode && !wait_opcode && !cpu_halt;
	endsequence
	sequence s_stack_end;
		stack_request && stack_done;
	endsequence
	// three samples of a quiet pin cover the two-stage synchroniser
	sequence s_stop_quiet;
		(!osc_enable && condition_code_reg[CC_I] && nonmaskable_request_n) [*3];
	endsequence

	a_wait_stacks: assert property (wait_opcode && !cpu_halt |=> stack_request)
		else $error("wait opcode did not start stacking");
	a_stop_enter: assert property (s_run_stop ##0 !condition_code_reg[CC_S] |=> !osc_enable)
		else $error("stop opcode did not stop the oscillator");
	a_stop_nop: assert property (s_run_stop ##0 condition_code_reg[CC_S] |=> osc_enable && !cpu_halt)
		else $error("stop opcode with s set was not ignored");
	a_wait_addr: assert property (s_stack_end |=> wait_bus_read && wait_bus_addr == $past(ccr_stack_addr))
		else $error("idle reads not aimed at the stacked ccr");
	a_wait_osc: assert property (wait_bus_read |-> osc_enable && cpu_halt)
		else $error("oscillator off or core running in wait");
	a_timer1_run: assert property (wait_bus_read && !condition_code_reg[CC_I] |-> timer1_clk_en)
		else $error("timer 1 halted in wait with i clear");
	a_stop_gated: assert property (!osc_enable |-> !timer1_clk_en && !timer2_clk_en && !timer3_clk_en
		&& pwm_clk_en == '0)
		else $error("peripheral clock running in stop");
	a_stop_masked: assert property (s_stop_quiet |=> !osc_enable)
		else $error("stop left with every wake source masked");
	a_irq_mask: assert property (irq_service_request |-> !condition_code_reg[CC_I])
		else $error("maskable request while i set");
	a_nmi_masks: assert property (int_taken && int_taken_nmi |=> condition_code_reg[1:0] == 2'h3)
		else $error("nonmaskable entry did not set x and i");
	a_rti_back: assert property (rti_restore && !int_taken |=> condition_code_reg == $past(rti_value))
		else $error("return did not restore the masks");
	a_nmi_next: assert property (nmi_continue_next |-> wake_resume)
		else $error("continue pulse without resume");
endmodule : lpwsc_props

bind lpwsc_top lpwsc_props u_lpwsc_props (.aclk, .aresetn, .wait_opcode, .stop_opcode, .stack_done,
	.ccr_stack_addr, .int_taken, .int_taken_nmi, .rti_restore, .rti_value, .nonmaskable_request_n,
	.condition_code_reg, .stack_request, .cpu_halt, .osc_enable, .wake_resume, .nmi_continue_next,
	.irq_service_request, .wait_bus_read, .wait_bus_addr, .timer1_clk_en, .timer2_clk_en, .timer3_clk_en,
	.pwm_clk_en);

// ---- verification/lpwsc_core_model.sv ----
// behavioural processor core that answers stacking requests
`timescale 1ns/100ps
module lpwsc_core_model #(
	parameter logic [15:0] STACK_ADDR = 16'h01F7 // where the ccr byte lands
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic stack_request, // controller asks for stacking
	input wire logic slow, // take several cycles to stack
	output logic stack_done, // stacking finished, pulse
	output logic [15:0] ccr_stack_addr // valid only with stack_done
);
	logic [2:0] cnt_reg;

	// nine pushes squeezed into a short count; address toggles while no stacking is asked, holds while counting
	always_ff @(posedge aclk) begin
		if (!aresetn || !stack_request || stack_done) begin
			cnt_reg <= 3'h0;
			stack_done <= 1'h0;
			ccr_stack_addr <= aresetn ? ~ccr_stack_addr : 16'h5A5A;
		end else if (cnt_reg >= (slow ? 3'h5 : 3'h0)) begin
			stack_done <= 1'h1;
			ccr_stack_addr <= STACK_ADDR;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
endmodule : lpwsc_core_model

// ---- verification/lpwsc_top_tb.sv ----
// self-checking bench for the low-power wait/stop controller
`timescale 1ns/100ps
module lpwsc_top_tb import lpwsc_pkg::*;;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam logic [15:0] STACK_ADDR = 16'h01F7;
	localparam int LIM = 50;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_word;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic irq_n_pin = 1'h1, nonmaskable_request_n = 1'h1, power_on_pin = 1'h1, slow = 1'h0;
	logic wait_opcode = 1'h0, stop_opcode = 1'h0, int_taken = 1'h0, int_taken_nmi = 1'h0, ccr_load = 1'h0;
	logic rti_restore = 1'h0, stack_done, stack_request, cpu_halt, osc_enable, wake_resume, nmi_continue_next;
	logic [2:0] ccr_load_value = 3'h0, rti_value = 3'h0, condition_code_reg;
	logic [7:0] periph_irq = 8'h00;
	logic [15:0] ccr_stack_addr, wait_bus_addr;
	logic irq_service_request, nmi_service_request, wait_bus_read, timer1_clk_en, timer2_clk_en, timer3_clk_en;
	logic converter_power, converter_clk_en, sync_serial_clk_en, async_tx_clk_en, async_rx_clk_en;
	logic [3:0] pwm_clk_en;
	int errors = 0;
	int check_count = 0;

	always #25 aclk = ~aclk;

	lpwsc_top #(.PERIPH_N(8), .RESTART_DELAY_CYCLES(4)) u_lpwsc_top (.*);
	lpwsc_core_model #(.STACK_ADDR(STACK_ADDR)) u_lpwsc_core_model (.aclk, .aresetn, .stack_request, .slow,
		.stack_done, .ccr_stack_addr);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// a wait that used up its bound ends the run
	task automatic guard(input int n);
		if (n >= LIM) begin
			errors++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			report_and_stop();
		end
	endtask : guard

	task automatic tick;
		@(posedge aclk);
		#1;
	endtask : tick

	function automatic logic [8:0] gates();
		return {converter_power, converter_clk_en, sync_serial_clk_en, async_tx_clk_en, async_rx_clk_en, pwm_clk_en};
	endfunction : gates

	// address and data offered together, bready held until the answer
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rexp);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < LIM; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1 && s_axi_wready === 1'h1) break;
		end
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		for (; n < LIM; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'h1) break;
		end
		guard(n);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, rexp);
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, input logic [1:0] rexp, output logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < LIM; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) break;
		end
		s_axi_arvalid <= 1'h0;
		for (; n < LIM; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'h1) break;
		end
		guard(n);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		chk(s_axi_rresp, rexp);
	endtask : axi_rd

	// kind: 4 = nonmaskable entry, 2 = ccr transfer, 1 = return
	task automatic core_pulse(input logic [2:0] kind, input logic [2:0] v);
		@(posedge aclk);
		{int_taken, ccr_load, rti_restore} <= kind;
		int_taken_nmi <= kind[2];
		ccr_load_value <= v;
		rti_value <= v;
		@(posedge aclk);
		{int_taken, ccr_load, rti_restore} <= 3'h0;
		tick();
	endtask : core_pulse

	task automatic op_pulse(input logic w, input logic s);
		@(posedge aclk);
		wait_opcode <= w;
		stop_opcode <= s;
		@(posedge aclk);
		wait_opcode <= 1'h0;
		stop_opcode <= 1'h0;
		tick();
	endtask : op_pulse

	task automatic do_reset(input logic por);
		int n;
		@(posedge aclk);
		aresetn <= 1'h0;
		power_on_pin <= por;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) tick();
		chk(cpu_halt, por);
		for (n = 0; n < LIM && cpu_halt !== 1'h0; n++) tick();
		guard(n);
	endtask : do_reset

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] wv[3] = '{32'h0A50, 32'h15A0, 32'h0001};
		logic [8:0] gx[3] = '{9'h145, 9'h0BA, 9'h000};
		axi_rd(LPWSC_CTRL_ADDR, RESP_OKAY, rd_word);
		chk(rd_word, {18'h0, CTL_RESET});
		for (int k = 0; k < 3; k++) begin
			axi_wr(LPWSC_CTRL_ADDR, wv[k], RESP_OKAY);
			chk(gates(), gx[k]);
		end
		axi_wr(4'hC, 32'hFFFF, RESP_SLVERR);
		axi_rd(4'hC, RESP_SLVERR, rd_word);
		chk(rd_word, 32'h0);
	endtask : t_regs

	// i set with watchdog off halts timer 1 and masks peripheral wake
	task automatic t_wait(input logic ibit);
		int n;
		axi_wr(LPWSC_CTRL_ADDR, 32'h0007, RESP_OKAY);
		slow <= ibit;
		core_pulse(3'h2, {2'h2, ibit});
		op_pulse(1'h1, 1'h0);
		chk(stack_request, 1'h1);
		for (n = 0; n < LIM && wait_bus_read !== 1'h1; n++) tick();
		guard(n);
		chk(wait_bus_addr, STACK_ADDR);
		chk(osc_enable, 1'h1);
		chk({timer1_clk_en, timer2_clk_en, timer3_clk_en}, {~ibit, 2'h1});
		@(posedge aclk);
		periph_irq <= 8'h80;
		repeat (4) tick();
		chk(cpu_halt, ibit);
		@(posedge aclk);
		nonmaskable_request_n <= 1'h0;
		for (n = 0; n < LIM && cpu_halt !== 1'h0; n++) tick();
		guard(n);
		repeat (2) tick();
		chk(nmi_service_request, 1'h1);
		@(posedge aclk);
		periph_irq <= 8'h00;
		nonmaskable_request_n <= 1'h1;
	endtask : t_wait

	task automatic t_stop_nmi;
		int n;
		axi_wr(LPWSC_CTRL_ADDR, 32'h1FF1, RESP_OKAY);
		core_pulse(3'h1, 3'h7);
		op_pulse(1'h0, 1'h1);
		chk({osc_enable, cpu_halt}, 2'h2);
		core_pulse(3'h1, 3'h3);
		op_pulse(1'h0, 1'h1);
		chk({osc_enable, gates(), timer1_clk_en, timer2_clk_en, timer3_clk_en}, 13'h0800);
		@(posedge aclk);
		irq_n_pin <= 1'h0;
		repeat (5) tick();
		chk(osc_enable, 1'h0);
		@(posedge aclk);
		nonmaskable_request_n <= 1'h0;
		for (n = 0; n < LIM && osc_enable !== 1'h1; n++) tick();
		guard(n);
		for (n = 0; n < LIM && cpu_halt !== 1'h0; n++) tick();
		chk(n, 4);
		chk({nmi_continue_next, cpu_halt, condition_code_reg}, 5'h13);
		@(posedge aclk);
		irq_n_pin <= 1'h1;
		nonmaskable_request_n <= 1'h1;
		repeat (3) tick();
		axi_wr(LPWSC_STAT_ADDR, 32'h1, RESP_OKAY);
	endtask : t_stop_nmi

	// flag holds the request after the pin lets go, until written off
	task automatic t_irq;
		int n;
		core_pulse(3'h2, 3'h0);
		axi_wr(LPWSC_CTRL_ADDR, 32'h0, RESP_OKAY);
		@(posedge aclk);
		irq_n_pin <= 1'h0;
		repeat (4) tick();
		chk(irq_service_request, 1'h1);
		@(posedge aclk);
		irq_n_pin <= 1'h1;
		repeat (4) tick();
		axi_rd(LPWSC_STAT_ADDR, RESP_OKAY, rd_word);
		chk({rd_word[ST_FLAG], irq_service_request}, 2'h3);
		axi_wr(LPWSC_STAT_ADDR, 32'h1, RESP_OKAY);
		tick();
		chk(irq_service_request, 1'h0);
		axi_wr(LPWSC_CTRL_ADDR, 32'h2000, RESP_OKAY);
		op_pulse(1'h0, 1'h1);
		chk(osc_enable, 1'h0);
		@(posedge aclk);
		irq_n_pin <= 1'h0;
		for (n = 0; n < LIM && osc_enable !== 1'h1; n++) tick();
		guard(n);
		tick();
		chk(cpu_halt, 1'h0);
		@(posedge aclk);
		irq_n_pin <= 1'h1;
		repeat (3) tick();
		axi_wr(LPWSC_STAT_ADDR, 32'h1, RESP_OKAY);
		core_pulse(3'h4, 3'h0);
		chk(condition_code_reg, 3'h3);
		core_pulse(3'h1, 3'h0);
		chk(condition_code_reg, 3'h0);
	endtask : t_irq

	initial begin
		do_reset(1'h1);
		t_regs();
		t_wait(1'h1);
		t_wait(1'h0);
		t_stop_nmi();
		t_irq();
		axi_wr(LPWSC_CTRL_ADDR, 32'h0, RESP_OKAY);
		do_reset(1'h0);
		axi_rd(LPWSC_CTRL_ADDR, RESP_OKAY, rd_word);
		chk(rd_word, {18'h0, CTL_RESET});
		report_and_stop();
	end
endmodule : lpwsc_top_tb
